/* pkg/xmb_pkg.sv */
package xmb_pkg;
    // Instruction clock
    localparam int CLK_MHZ = 40;
    // Read data window on the pins, then two sync stages
    localparam int RD_PHASE_NS = 75;
    localparam int RD_PHASE_CYC_I = (RD_PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] RD_PHASE_CYC = RD_PHASE_CYC_I[1:0];
    // Size of on-chip program memory in bytes
    localparam logic [20:0] ONCHIP_SIZE = 21'h020000;
    localparam logic [20:0] BUS_BOTTOM = 21'h000000;
    // Avalon byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PULLUP = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    // Bus control register fields
    localparam int CTRL_DIS_BIT = 7;
    localparam int CTRL_WAIT_LSB = 4;
    localparam int CTRL_WM_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hB3;
    // Pull-up register fields
    localparam int PU_LOW_BIT = 0;
    localparam int PU_HIGH_BIT = 1;
    localparam int PU_CTRL_BIT = 2;
    localparam logic [2:0] PULLUP_RESET = 3'h0;
    // Status register fields
    localparam int ST_BUSOWN_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_EXTMODE_BIT = 2;
    localparam int ST_EFFDIS_BIT = 3;
    // Address width strap codes
    localparam logic [1:0] AW_12 = 2'h0;
    localparam logic [1:0] AW_16 = 2'h1;
    localparam logic [1:0] AW_20 = 2'h2;
    // Request kinds
    localparam logic [1:0] KIND_FETCH = 2'h0;
    localparam logic [1:0] KIND_TBLRD = 2'h1;
    localparam logic [1:0] KIND_TABLE_WRITE_OP = 2'h2;
    localparam logic [1:0] WAIT_MAX = 2'h3;
    typedef enum logic [1:0] {WM_BYTE_WRITE, WM_BYTE_SELECT, WM_WORD_WRITE} xmb_width_e;
endpackage : xmb_pkg

/* testbench/tb_xmb_bus_interface.sv */
`timescale 1ns/10ps
module tb_xmb_bus_interface;
    logic clock = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, strapExtMode = 1'b1, strapData16 = 1'b1;
    logic addr_shift_cfg = 1'b1, strapWaitEnable = 1'b1, sleepMode = 1'b0, reqValid = 1'b0;
    logic [1:0] strapAddrWidth = xmb_pkg::AW_20, reqKind = 2'h0;
    logic [20:0] reqAddr = 21'h000000, latched, ext;
    logic [7:0] table_latch_reg = 8'h00;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, upper_addr_lines, upperAddrOe, busOwnsUpper;
    logic avs_read = 1'b0, avs_write = 1'b0, reqReady, respValid, respExternal, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [15:0] respData, addrDataIn, addr_data_lines, addrDataOe, busOwnsAd, memOut, wrData;
    logic addrLatchEn, outputEnN, write_high_strobe_n, write_low_strobe_n, byte_addr_line, chipEnN;
    logic lower_byte_en_n, upper_byte_en_n, busOwnsCtrl, pullup_en_low_ad, pullup_en_high_ad, pullup_en_ctrl;
    logic hiSeen, loSeen, ownAtLatch;
    logic [2:0] wrSel;
    int fails = 0, num_checks = 0, lat;
    int lats[4];
    always #12.5 clock = ~clock;
    assign addrDataIn = (addr_data_lines & addrDataOe) | (memOut & ~addrDataOe);
    xmb_bus_interface xmb_bus_interface_i (.*);
    xmb_mem_model xmb_mem_model_i (.clock(clock), .bus16(strapData16), .adOut(addr_data_lines),
        .upOut(upper_addr_lines), .latchEn(addrLatchEn), .oeN(outputEnN), .ceN(chipEnN),
        .byteSel(byte_addr_line), .memOut(memOut));
    always @(posedge clock) begin
        if (addrLatchEn) begin
            latched = {upper_addr_lines, addr_data_lines, byte_addr_line};
            ownAtLatch = busOwnsCtrl;
        end
        if (!write_high_strobe_n || !write_low_strobe_n) begin
            hiSeen = !write_high_strobe_n;
            loSeen = !write_low_strobe_n;
            wrData = addr_data_lines;
            wrSel = {byte_addr_line, upper_byte_en_n, lower_byte_en_n};
        end
    end
    task conclude;
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    task req(input logic [1:0] k, input logic [20:0] a, input logic [7:0] d);
        @(posedge clock);
        reqKind <= k;
        reqAddr <= a;
        table_latch_reg <= d;
        reqValid <= 1'b1;
        do @(posedge clock); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        lat = 0;
        do begin
            @(posedge clock);
            lat++;
        end while (respValid !== 1'b1);
    endtask : req
    task boot(input logic e, input logic d16, input logic [1:0] aw, input logic sh);
        @(posedge clock);
        sys_rst <= 1'b1;
        strapExtMode <= e;
        strapData16 <= d16;
        strapAddrWidth <= aw;
        addr_shift_cfg <= sh;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
    endtask : boot
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        conclude();
    end
    initial begin
        boot(1'b1, 1'b1, xmb_pkg::AW_20, 1'b1);
        ext = xmb_pkg::ONCHIP_SIZE + 21'h000246;
        av(1'b0, xmb_pkg::OFS_PULLUP, 32'h0);
        chk(q, 32'h0);
        av(1'b1, xmb_pkg::OFS_PULLUP, 32'h7);
        av(1'b0, xmb_pkg::OFS_PULLUP, 32'h0);
        chk({q[2:0], pullup_en_ctrl, pullup_en_high_ad, pullup_en_low_ad}, 32'h3F);
        req(xmb_pkg::KIND_FETCH, 21'h000100, 8'h00);
        chk(respExternal, 1'b0);
        chk({busOwnsCtrl, chipEnN, addrDataOe}, {2'b11, 16'h0});
        chk(busOwnsAd, 16'hFFFF);
        req(xmb_pkg::KIND_FETCH, ext, 8'h00);
        chk(latched, 21'h000246);
        chk({respExternal, respData}, {1'b1, 16'h0123 ^ 16'hC3A5});
        av(1'b1, xmb_pkg::OFS_CTRL, 32'hB0);
        chk(busOwnsCtrl, 1'b1);
        req(xmb_pkg::KIND_FETCH, 21'h000100, 8'h00);
        repeat (2) @(posedge clock);
        chk(busOwnsCtrl, 1'b0);
        av(1'b0, xmb_pkg::OFS_STATUS, 32'h0);
        chk(q, 32'hC);
        req(xmb_pkg::KIND_TBLRD, ext, 8'h00);
        chk({ownAtLatch, respExternal}, 2'b11);
        for (int c = 0; c < 4; c++) begin
            av(1'b1, xmb_pkg::OFS_CTRL, c << 4);
            req(xmb_pkg::KIND_TBLRD, ext, 8'h00);
            lats[c] = lat;
        end
        for (int c = 0; c < 4; c++) chk(lats[c] - lats[3], 3 - c);
        for (int m = 0; m < 3; m++) begin
            av(1'b1, xmb_pkg::OFS_CTRL, 32'h30 | (m == 2 ? 3 : m));
            for (int p = 0; p < 2; p++) begin
                hiSeen = 1'b0;
                loSeen = 1'b0;
                req(xmb_pkg::KIND_TABLE_WRITE_OP, ext + p, p ? 8'hB2 : 8'hA1);
                chk({hiSeen, loSeen}, m == 0 ? (p ? 2'b10 : 2'b01) : (m == 2 && p == 0) ? 2'b00 : 2'b10);
                if (m != 2 || p == 1) chk(wrData, m == 2 ? 16'hB2A1 : (p ? 16'hB2B2 : 16'hA1A1));
                if (m == 1) chk(wrSel, p ? 3'b101 : 3'b010);
            end
        end
        sleepMode <= 1'b1;
        repeat (3) @(posedge clock);
        chk({chipEnN, upper_byte_en_n, lower_byte_en_n}, 3'h7);
        sleepMode <= 1'b0;
        strapWaitEnable <= 1'b0;
        boot(1'b1, 1'b0, xmb_pkg::AW_16, 1'b0);
        req(xmb_pkg::KIND_FETCH, 21'h030246, 8'h00);
        chk(latched[16:0], 17'h10246);
        chk(respData, 16'h8123 ^ 16'hC3A5);
        chk({busOwnsUpper, upperAddrOe}, 8'h00);
        req(xmb_pkg::KIND_TBLRD, 21'h030246, 8'h00);
        chk(lat, lats[3]);
        chk(respData, 16'h0086);
        boot(1'b0, 1'b1, xmb_pkg::AW_20, 1'b0);
        av(1'b1, xmb_pkg::OFS_CTRL, 32'h80);
        av(1'b0, xmb_pkg::OFS_CTRL, 32'h0);
        chk({q[30:0], busOwnsCtrl}, 32'h0);
        conclude();
    end
endmodule : tb_xmb_bus_interface

/* testbench/xmb_bus_interface_assertions.sv */
`timescale 1ns/10ps
module xmb_bus_interface_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic sleepMode,
    input wire logic strapExtMode,
    input wire logic strapData16,
    input wire logic [1:0] strapAddrWidth,
    input wire logic respValid,
    input wire logic respExternal,
    input wire logic [15:0] addrDataOe,
    input wire logic [3:0] busOwnsUpper,
    input wire logic busOwnsCtrl,
    input wire logic addrLatchEn,
    input wire logic outputEnN,
    input wire logic write_high_strobe_n,
    input wire logic write_low_strobe_n,
    input wire logic chipEnN,
    input wire logic lower_byte_en_n,
    input wire logic upper_byte_en_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    AST_LATCH_PULSE: assert property (addrLatchEn |-> (!chipEnN && outputEnN) ##1 !addrLatchEn)
        else $error("Latch pulse malformed");
    AST_OE_AFTER_LATCH: assert property ($fell(outputEnN) && strapData16 |-> $past(addrLatchEn))
        else $error("Output enable without latch");
    AST_OE_BUS_FREE: assert property (!outputEnN |-> (addrDataOe & (strapData16 ? 16'hFFFF : 16'h00FF)) == 16'h0000)
        else $error("Lines driven while memory drives");
    AST_ONE_STROBE: assert property (write_high_strobe_n || write_low_strobe_n)
        else $error("Both write strobes low");
    AST_PARKED_IDLE: assert property (chipEnN && !sleepMode && !$past(sleepMode)
        |-> outputEnN && write_high_strobe_n && write_low_strobe_n && !addrLatchEn)
        else $error("Parked control pins not idle");
    AST_SLEEP_IDLE: assert property (sleepMode && clkEn |=> chipEnN && lower_byte_en_n && upper_byte_en_n)
        else $error("Chip or byte enable low in sleep");
    AST_UPPER_FREE: assert property (strapAddrWidth != xmb_pkg::AW_20 |-> busOwnsUpper == 4'h0)
        else $error("Upper lines taken at narrow width");
    AST_ONCHIP_OFF: assert property (!strapExtMode |-> !busOwnsCtrl && chipEnN)
        else $error("Bus active in on-chip mode");
    AST_RESP_PULSE: assert property (respValid |=> !respValid)
        else $error("Response longer than one cycle");
    COV_EXT_FETCH: cover property (respValid && respExternal);
    COV_WRITE_HIGH: cover property (!write_high_strobe_n);
    COV_SLEEP: cover property (sleepMode && clkEn);
endmodule : xmb_bus_interface_assertions
bind xmb_bus_interface xmb_bus_interface_assertions xmb_bus_interface_assertions_i (.*);

/* testbench/xmb_mem_model.sv */
`timescale 1ns/10ps
module xmb_mem_model (
    input wire logic clock,
    input wire logic bus16,
    input wire logic [15:0] adOut,
    input wire logic [3:0] upOut,
    input wire logic latchEn,
    input wire logic oeN,
    input wire logic ceN,
    input wire logic byteSel,
    output logic [15:0] memOut
);
    logic [19:0] latAddr = 20'h00000;
    logic [15:0] word;
    assign word = latAddr[15:0] ^ 16'hC3A5;
    // Asynchronous part: data follows enables, pulled high when released
    assign memOut = (!oeN && !ceN) ? (bus16 ? word : {2{byteSel ? word[15:8] : word[7:0]}}) : 16'hFFFF;
    always @(posedge clock) begin
        if (latchEn) begin
            latAddr <= {upOut, adOut};
        end
    end
endmodule : xmb_mem_model

/* verilog/xmb_bus_interface.sv */
`timescale 1ns/10ps
// What this block does
// - Unshifted bus address equals program counter
// - Shift config subtracts on-chip size from address
// - Byte address line is address LSb, held low for 16-bit word and byte writes
// - Data shares low lines per data width
// - Wait enable adds wait count cycles to table reads and writes, not to fetches
// - Three pull-up enables, cleared on reset
// - On-chip mode: bus off, control writes ignored
// - External fetch or table op uses bus
// - Internal execution: disable bit picks pin function
// - External access overrides disable bit temporarily
// - Disable takes effect after branch to internal
// - Parked bus: tri-state data, strobes idle
// - Only configured address width lines are parked
// - Bus overrides all other pin functions
// - Width mode selects 16-bit write configuration
// - Width mode decode: 1x word, 01 select, 00 byte
// - Latch pulse with address, then output enable
// - Chip enable low per access, high in sleep
// - Byte select drives byte address and enables
// - Byte write: latch byte both halves, strobe by LSb
// - Wait code 11,10,01,00 gives 0,1,2,3 cycles
// - Word write: even holds, odd writes pair
module xmb_bus_interface (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic strapExtMode,
    input wire logic strapData16,
    input wire logic [1:0] strapAddrWidth,
    input wire logic addr_shift_cfg,
    input wire logic strapWaitEnable,
    input wire logic sleepMode,
    input wire logic reqValid,
    input wire logic [1:0] reqKind,
    input wire logic [20:0] reqAddr,
    input wire logic [7:0] table_latch_reg,
    output logic reqReady,
    output logic respValid,
    output logic [15:0] respData,
    output logic respExternal,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] addrDataIn,
    output logic [15:0] addr_data_lines,
    output logic [15:0] addrDataOe,
    output logic [3:0] upper_addr_lines,
    output logic [3:0] upperAddrOe,
    output logic addrLatchEn,
    output logic outputEnN,
    output logic write_high_strobe_n,
    output logic write_low_strobe_n,
    output logic byte_addr_line,
    output logic chipEnN,
    output logic lower_byte_en_n,
    output logic upper_byte_en_n,
    output logic [15:0] busOwnsAd,
    output logic [3:0] busOwnsUpper,
    output logic busOwnsCtrl,
    output logic pullup_en_low_ad,
    output logic pullup_en_high_ad,
    output logic pullup_en_ctrl
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RD, ST_RD2, ST_WR, ST_WAIT, ST_DONE} xmb_state_e;

    function automatic xmb_pkg::xmb_width_e decodeWidth(input logic [1:0] wm);
        if (wm[1]) begin
            decodeWidth = xmb_pkg::WM_WORD_WRITE;
        end else if (wm[0]) begin
            decodeWidth = xmb_pkg::WM_BYTE_SELECT;
        end else begin
            decodeWidth = xmb_pkg::WM_BYTE_WRITE;
        end
    endfunction : decodeWidth

    function automatic logic [15:0] adActiveMask(input logic [1:0] aw);
        if (aw == xmb_pkg::AW_12) begin
            adActiveMask = 16'h0FFF;
        end else begin
            adActiveMask = 16'hFFFF;
        end
    endfunction : adActiveMask

    // Strap and pin synchronisers
    logic [5:0] strapMeta_reg;
    logic [5:0] strapSync_reg;
    logic [15:0] adMeta_reg;
    logic [15:0] adSync_reg;
    logic strapsLoaded_reg;
    logic extMode_reg;
    logic data16_reg;
    logic [1:0] addrWidth_reg;
    logic shiftCfg_reg;
    logic waitEn_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strapMeta_reg <= 6'h00;
            strapSync_reg <= 6'h00;
            adMeta_reg <= 16'h0000;
            adSync_reg <= 16'h0000;
        end else if (clkEn) begin
            strapMeta_reg <= {strapExtMode, strapData16, strapAddrWidth, addr_shift_cfg, strapWaitEnable};
            strapSync_reg <= strapMeta_reg;
            adMeta_reg <= addrDataIn;
            adSync_reg <= adMeta_reg;
        end
    end

    // Straps caught once, after the sync chain has filled
    logic [1:0] strapCnt_reg;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strapCnt_reg <= 2'h0;
            strapsLoaded_reg <= 1'b0;
            extMode_reg <= 1'b0;
            data16_reg <= 1'b1;
            addrWidth_reg <= xmb_pkg::AW_20;
            shiftCfg_reg <= 1'b0;
            waitEn_reg <= 1'b0;
        end else if (clkEn && !strapsLoaded_reg) begin
            strapCnt_reg <= strapCnt_reg + 2'h1;
            if (strapCnt_reg == 2'h2) begin
                strapsLoaded_reg <= 1'b1;
                extMode_reg <= strapSync_reg[5];
                data16_reg <= strapSync_reg[4];
                addrWidth_reg <= strapSync_reg[3:2];
                shiftCfg_reg <= strapSync_reg[1];
                waitEn_reg <= strapSync_reg[0];
            end
        end
    end

    // Software registers
    logic [7:0] ctrl_reg;
    logic [2:0] pullup_reg;
    logic ack_reg;
    logic effDis_reg;
    logic lastFetchExt_reg;
    xmb_state_e state_reg;
    logic busOwn_reg;

    logic bus_disable_bit;
    logic [1:0] waitField;
    xmb_pkg::xmb_width_e widthMode;
    assign bus_disable_bit = ctrl_reg[xmb_pkg::CTRL_DIS_BIT];
    assign waitField = ctrl_reg[xmb_pkg::CTRL_WAIT_LSB +: 2];
    assign widthMode = decodeWidth(ctrl_reg[xmb_pkg::CTRL_WM_LSB +: 2]);

    logic busAccess;
    assign busAccess = (avs_read || avs_write) && !ack_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (clkEn) begin
            ack_reg <= busAccess;
            avs_waitrequest <= !busAccess;
            if (busAccess && avs_read) begin
                if (avs_address == xmb_pkg::OFS_CTRL) begin
                    avs_readdata <= {24'h000000, ctrl_reg};
                end else if (avs_address == xmb_pkg::OFS_PULLUP) begin
                    avs_readdata <= {29'h00000000, pullup_reg};
                end else if (avs_address == xmb_pkg::OFS_STATUS) begin
                    avs_readdata <= {28'h0000000, effDis_reg, extMode_reg, state_reg != ST_IDLE, busOwn_reg};
                end else begin
                    avs_readdata <= 32'h00000000;
                end
            end
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= xmb_pkg::CTRL_RESET;
            pullup_reg <= xmb_pkg::PULLUP_RESET;
        end else if (clkEn && ack_reg && avs_write && avs_byteenable[0]) begin
            if (avs_address == xmb_pkg::OFS_CTRL && extMode_reg) begin
                ctrl_reg <= avs_writedata[7:0] & xmb_pkg::CTRL_MASK;
            end else if (avs_address == xmb_pkg::OFS_PULLUP) begin
                pullup_reg <= avs_writedata[2:0];
            end
        end
    end
    assign pullup_en_low_ad = pullup_reg[xmb_pkg::PU_LOW_BIT];
    assign pullup_en_high_ad = pullup_reg[xmb_pkg::PU_HIGH_BIT];
    assign pullup_en_ctrl = pullup_reg[xmb_pkg::PU_CTRL_BIT];

    // Request decode
    logic [20:0] busAddr;
    logic reqExternal;
    assign reqExternal = extMode_reg && strapsLoaded_reg && (reqAddr >= xmb_pkg::ONCHIP_SIZE);
    assign busAddr = shiftCfg_reg ? (reqAddr - xmb_pkg::ONCHIP_SIZE) : reqAddr;

    // Disable bit takes hold only once execution is internal
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lastFetchExt_reg <= 1'b0;
            effDis_reg <= 1'b0;
        end else if (clkEn) begin
            if (state_reg == ST_IDLE && reqValid && reqKind == xmb_pkg::KIND_FETCH) begin
                lastFetchExt_reg <= reqExternal;
            end
            if (!lastFetchExt_reg) begin
                effDis_reg <= bus_disable_bit;
            end
        end
    end

    // Bus cycle sequencer and pin registers
    logic [1:0] kind_reg;
    logic [20:0] addr_reg;
    logic [1:0] phaseCnt_reg;
    logic [7:0] hold_reg;
    logic [7:0] lowByte_reg;
    logic [15:0] adActive;
    assign adActive = adActiveMask(addrWidth_reg);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            kind_reg <= xmb_pkg::KIND_FETCH;
            addr_reg <= xmb_pkg::BUS_BOTTOM;
            phaseCnt_reg <= 2'h0;
            hold_reg <= 8'h00;
            lowByte_reg <= 8'h00;
            reqReady <= 1'b0;
            respValid <= 1'b0;
            respData <= 16'h0000;
            respExternal <= 1'b0;
            addr_data_lines <= 16'h0000;
            addrDataOe <= 16'h0000;
            upper_addr_lines <= 4'h0;
            upperAddrOe <= 4'h0;
            addrLatchEn <= 1'b0;
            outputEnN <= 1'b1;
            write_high_strobe_n <= 1'b1;
            write_low_strobe_n <= 1'b1;
            byte_addr_line <= 1'b0;
            chipEnN <= 1'b1;
            lower_byte_en_n <= 1'b1;
            upper_byte_en_n <= 1'b1;
        end else if (clkEn) begin
            respValid <= 1'b0;
            if (sleepMode) begin
                reqReady <= 1'b0;
                chipEnN <= 1'b1;
                lower_byte_en_n <= 1'b1;
                upper_byte_en_n <= 1'b1;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        reqReady <= strapsLoaded_reg;
                        addrDataOe <= 16'h0000;
                        upperAddrOe <= 4'h0;
                        addrLatchEn <= 1'b0;
                        outputEnN <= 1'b1;
                        write_high_strobe_n <= 1'b1;
                        write_low_strobe_n <= 1'b1;
                        byte_addr_line <= 1'b0;
                        chipEnN <= 1'b1;
                        lower_byte_en_n <= 1'b1;
                        upper_byte_en_n <= 1'b1;
                        if (reqValid && reqReady) begin
                            reqReady <= 1'b0;
                            kind_reg <= reqKind;
                            addr_reg <= busAddr;
                            respExternal <= reqExternal;
                            if (reqExternal) begin
                                state_reg <= ST_ADDR;
                            end else begin
                                state_reg <= ST_DONE;
                            end
                        end
                    end
                    ST_ADDR: begin
                        chipEnN <= 1'b0;
                        addrLatchEn <= 1'b1;
                        addr_data_lines <= addr_reg[16:1];
                        addrDataOe <= adActive;
                        upper_addr_lines <= addr_reg[20:17];
                        upperAddrOe <= (addrWidth_reg == xmb_pkg::AW_20) ? 4'hF : 4'h0;
                        byte_addr_line <= (kind_reg == xmb_pkg::KIND_FETCH) ? 1'b0 : addr_reg[0];
                        phaseCnt_reg <= 2'h0;
                        state_reg <= (kind_reg == xmb_pkg::KIND_TABLE_WRITE_OP) ? ST_WR : ST_RD;
                    end
                    ST_RD, ST_RD2: begin
                        addrLatchEn <= 1'b0;
                        outputEnN <= 1'b0;
                        addrDataOe <= adActive & (data16_reg ? 16'h0000 : 16'hFF00);
                        if (data16_reg) begin
                            lower_byte_en_n <= 1'b0;
                            upper_byte_en_n <= 1'b0;
                        end
                        phaseCnt_reg <= phaseCnt_reg + 2'h1;
                        if (phaseCnt_reg == xmb_pkg::RD_PHASE_CYC) begin
                            phaseCnt_reg <= 2'h0;
                            if (data16_reg) begin
                                respData <= adSync_reg;
                                state_reg <= (kind_reg == xmb_pkg::KIND_FETCH) ? ST_DONE : ST_WAIT;
                            end else if (state_reg == ST_RD && kind_reg == xmb_pkg::KIND_FETCH) begin
                                lowByte_reg <= adSync_reg[7:0];
                                byte_addr_line <= 1'b1;
                                state_reg <= ST_RD2;
                            end else if (state_reg == ST_RD2) begin
                                respData <= {adSync_reg[7:0], lowByte_reg};
                                state_reg <= ST_DONE;
                            end else begin
                                respData <= {8'h00, adSync_reg[7:0]};
                                state_reg <= ST_WAIT;
                            end
                        end
                    end
                    ST_WR: begin
                        addrLatchEn <= 1'b0;
                        phaseCnt_reg <= 2'h0;
                        state_reg <= ST_WAIT;
                        addr_data_lines <= {table_latch_reg, table_latch_reg};
                        addrDataOe <= adActive;
                        if (!data16_reg) begin
                            addr_data_lines <= {addr_reg[16:9], table_latch_reg};
                            write_low_strobe_n <= 1'b0;
                        end else if (widthMode == xmb_pkg::WM_WORD_WRITE) begin
                            if (!addr_reg[0]) begin
                                hold_reg <= table_latch_reg;
                                addrDataOe <= 16'h0000;
                            end else begin
                                addr_data_lines <= {table_latch_reg, hold_reg};
                                write_high_strobe_n <= 1'b0;
                                lower_byte_en_n <= 1'b0;
                                upper_byte_en_n <= 1'b0;
                            end
                        end else if (widthMode == xmb_pkg::WM_BYTE_SELECT) begin
                            write_high_strobe_n <= 1'b0;
                            upper_byte_en_n <= !addr_reg[0];
                            lower_byte_en_n <= addr_reg[0];
                        end else begin
                            write_high_strobe_n <= !addr_reg[0];
                            write_low_strobe_n <= addr_reg[0];
                        end
                        if (data16_reg && widthMode != xmb_pkg::WM_BYTE_SELECT) begin
                            byte_addr_line <= 1'b0;
                        end
                    end
                    ST_WAIT: begin
                        outputEnN <= 1'b1;
                        write_high_strobe_n <= 1'b1;
                        write_low_strobe_n <= 1'b1;
                        if (!waitEn_reg || phaseCnt_reg == (xmb_pkg::WAIT_MAX - waitField)) begin
                            state_reg <= ST_DONE;
                        end else begin
                            phaseCnt_reg <= phaseCnt_reg + 2'h1;
                        end
                    end
                    ST_DONE: begin
                        respValid <= 1'b1;
                        outputEnN <= 1'b1;
                        chipEnN <= 1'b1;
                        addrDataOe <= 16'h0000;
                        lower_byte_en_n <= 1'b1;
                        upper_byte_en_n <= 1'b1;
                        state_reg <= ST_IDLE;
                        reqReady <= strapsLoaded_reg;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Pin ownership: bus wins over ports and peripherals
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busOwn_reg <= 1'b0;
            busOwnsAd <= 16'h0000;
            busOwnsUpper <= 4'h0;
            busOwnsCtrl <= 1'b0;
        end else if (clkEn) begin
            busOwn_reg <= extMode_reg && strapsLoaded_reg && (!effDis_reg || state_reg != ST_IDLE);
            if (extMode_reg && strapsLoaded_reg && (!effDis_reg || state_reg != ST_IDLE)) begin
                busOwnsAd <= adActive;
                busOwnsUpper <= (addrWidth_reg == xmb_pkg::AW_20) ? 4'hF : 4'h0;
                busOwnsCtrl <= 1'b1;
            end else begin
                busOwnsAd <= 16'h0000;
                busOwnsUpper <= 4'h0;
                busOwnsCtrl <= 1'b0;
            end
        end
    end
endmodule : xmb_bus_interface
